// ==== hdl/rsa_alu.sv ====
// Rotate, subtract, step-and-skip and set datapath of the 8-bit core
//
// Behaviour
// - Rotate left to accumulator, memory untouched
// - Rotate left through carry in memory
// - Rotate left through carry into accumulator
// - Rotate right in place, no flags
// - Rotate right into accumulator, memory untouched
// - Rotate right through carry in memory
// - Rotate right through carry into accumulator
// - Borrow subtract of memory into accumulator
// - Borrow subtract of immediate into accumulator
// - Borrow subtract result written to memory
// - Carry cleared on negative, set otherwise
// - Subtracts update six arithmetic flags
// - Plain subtract ignores carry, either destination
// - Decrement memory, skip when zero
// - Decrement into accumulator, skip when zero
// - Increment memory, skip when zero
// - Increment into accumulator, skip when zero
// - Skip when byte or bit nonzero
// - Skip instructions take two cycles
// - Set byte writes all ones
// - Set bit forces one selected bit
module rsa_alu #(
	parameter int DW = rsa_pkg::DATA_W
) (
	// Clock and reset
	input  wire logic                sys_clk,
	input  wire logic                rst_n,
	// Command from the instruction sequencer
	input  wire logic                cmd_valid,
	input  wire rsa_pkg::rsa_cmd_t   cmd,
	output logic                     cmd_ready,
	// Accumulator and flag preload by the rest of the core
	input  wire logic                acc_load,
	input  wire logic [DW-1:0]       acc_load_data,
	input  wire logic                flags_load,
	input  wire rsa_pkg::rsa_flags_t flags_load_data,
	// Data memory write-back
	output logic                     mem_we,
	output logic [DW-1:0]            mem_wdata,
	// Sequencer control
	output logic                     skip_next,
	output logic                     dummy_cycle,
	// Architectural state
	output logic [DW-1:0]            accumulator,
	output rsa_pkg::rsa_flags_t      flags
);

	// ------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------

	// Skip-type decode, used only by the state logic to enter the dummy slot
	function automatic logic is_skip_op(input rsa_pkg::rsa_op_t op);
		is_skip_op = (op == rsa_pkg::RSA_DECREMENT_SKIP_ZERO)
		          || (op == rsa_pkg::RSA_DECREMENT_SKIP_ZERO_TO_ACC)
		          || (op == rsa_pkg::RSA_INCREMENT_SKIP_ZERO)
		          || (op == rsa_pkg::RSA_INCREMENT_SKIP_ZERO_TO_ACC)
		          || (op == rsa_pkg::RSA_SKIP_IF_NONZERO)
		          || (op == rsa_pkg::RSA_SKIP_IF_NONZERO_BIT);
	endfunction

	// One-hot mask of the selected bit
	function automatic logic [7:0] bit_mask(input logic [2:0] sel);
		bit_mask = 8'h01 << sel;
	endfunction

	// ------------------------------------------------------------
	// State registers
	// ------------------------------------------------------------
	rsa_pkg::rsa_state_t state_reg, state_next;
	rsa_pkg::rsa_flags_t flags_reg, flags_next;
	logic [DW-1:0]       acc_reg, acc_next;
	logic [DW-1:0]       mem_wdata_reg, mem_wdata_next;
	logic                mem_we_reg, mem_we_next;
	logic                skip_reg, skip_next_v;

	logic                take;
	logic [DW-1:0]       mem_val;
	logic [DW-1:0]       sub_opnd;
	logic                sub_cin;
	logic [DW:0]         sub_full;
	logic [4:0]          sub_low;
	logic [DW-1:0]       sub_res;
	logic [DW-1:0]       dec_res;
	logic [DW-1:0]       inc_res;
	logic                sub_ovfl;

	assign take    = cmd_valid && cmd_ready;
	assign mem_val = cmd.mem_data;

	// ------------------------------------------------------------
	// Arithmetic units
	// ------------------------------------------------------------

	// Subtraction as a + ~b + cin; carry-out high means no borrow
	always_comb begin
		sub_opnd = mem_val;
		sub_cin  = 1'b1;
		if ((cmd.op == rsa_pkg::RSA_SUBTRACT_WITH_BORROW_IMM)
		    || (cmd.op == rsa_pkg::RSA_PLAIN_SUBTRACT_IMM)) begin
			sub_opnd = cmd.imm;
		end
		// Borrow forms take away the inverse of carry
		if ((cmd.op == rsa_pkg::RSA_SUBTRACT_WITH_BORROW)
		    || (cmd.op == rsa_pkg::RSA_SUBTRACT_WITH_BORROW_IMM)
		    || (cmd.op == rsa_pkg::RSA_SUBTRACT_WITH_BORROW_TO_MEM)) begin
			sub_cin = flags_reg.carry_flag;
		end
	end

	assign sub_full = {1'b0, acc_reg} + {1'b0, ~sub_opnd}
	                + {8'h00, sub_cin};
	assign sub_low  = {1'b0, acc_reg[3:0]} + {1'b0, ~sub_opnd[3:0]}
	                + {4'h0, sub_cin};
	assign sub_res  = sub_full[DW-1:0];
	// Overflow: operands of unlike sign and result sign off the minuend
	assign sub_ovfl = (acc_reg[DW-1] != sub_opnd[DW-1])
	               && (sub_res[DW-1] != acc_reg[DW-1]);
	// Wrap-around is intended: 00 steps down to FF and FF up to 00
	assign dec_res  = mem_val - rsa_pkg::STEP_ONE;
	assign inc_res  = mem_val + rsa_pkg::STEP_ONE;

	// ------------------------------------------------------------
	// Next-state and result computation
	// ------------------------------------------------------------
	always_comb begin
		state_next     = state_reg;
		flags_next     = flags_reg;
		acc_next       = acc_reg;
		mem_wdata_next = mem_wdata_reg;
		mem_we_next    = 1'b0;
		skip_next_v    = 1'b0;

		// Preloads from the rest of the core; a taken command wins below
		if (acc_load) begin
			acc_next = acc_load_data;
		end
		if (flags_load) begin
			flags_next = flags_load_data;
		end

		unique case (state_reg)
			rsa_pkg::RSA_ST_EXEC: begin
				if (take && is_skip_op(cmd.op)) begin
					state_next = rsa_pkg::RSA_ST_DUMMY;
				end
			end
			rsa_pkg::RSA_ST_DUMMY: begin
				// Dummy slot while the following instruction is fetched
				state_next = rsa_pkg::RSA_ST_EXEC;
			end
			default: begin
				state_next = rsa_pkg::RSA_ST_EXEC;
			end
		endcase

		if (take) begin
			unique case (cmd.op)
				rsa_pkg::RSA_ROTATE_LEFT_IN_PLACE: begin
					mem_wdata_next = {mem_val[6:0], mem_val[7]};
					mem_we_next    = 1'b1;
				end
				rsa_pkg::RSA_ROTATE_LEFT_TO_ACC: begin
					acc_next = {mem_val[6:0], mem_val[7]};
				end
				rsa_pkg::RSA_ROTATE_LEFT_THRU_CARRY: begin
					mem_wdata_next = {mem_val[6:0],
					                  flags_reg.carry_flag};
					mem_we_next    = 1'b1;
					flags_next.carry_flag = mem_val[7];
				end
				rsa_pkg::RSA_ROTATE_LEFT_THRU_CARRY_TO_ACC: begin
					acc_next = {mem_val[6:0],
					            flags_reg.carry_flag};
					flags_next.carry_flag = mem_val[7];
				end
				rsa_pkg::RSA_ROTATE_RIGHT_IN_PLACE: begin
					mem_wdata_next = {mem_val[0], mem_val[7:1]};
					mem_we_next    = 1'b1;
				end
				rsa_pkg::RSA_ROTATE_RIGHT_TO_ACC: begin
					acc_next = {mem_val[0], mem_val[7:1]};
				end
				rsa_pkg::RSA_ROTATE_RIGHT_THRU_CARRY: begin
					mem_wdata_next = {flags_reg.carry_flag,
					                  mem_val[7:1]};
					mem_we_next    = 1'b1;
					flags_next.carry_flag = mem_val[0];
				end
				rsa_pkg::RSA_ROTATE_RIGHT_THRU_CARRY_TO_ACC: begin
					acc_next = {flags_reg.carry_flag,
					            mem_val[7:1]};
					flags_next.carry_flag = mem_val[0];
				end
				rsa_pkg::RSA_SUBTRACT_WITH_BORROW,
				rsa_pkg::RSA_SUBTRACT_WITH_BORROW_IMM,
				rsa_pkg::RSA_SUBTRACT_WITH_BORROW_TO_MEM,
				rsa_pkg::RSA_PLAIN_SUBTRACT,
				rsa_pkg::RSA_PLAIN_SUBTRACT_IMM,
				rsa_pkg::RSA_PLAIN_SUBTRACT_TO_MEM: begin
					// Memory forms write back, the others load the acc
					if ((cmd.op == rsa_pkg::RSA_SUBTRACT_WITH_BORROW_TO_MEM)
					    || (cmd.op == rsa_pkg::RSA_PLAIN_SUBTRACT_TO_MEM)) begin
						mem_wdata_next = sub_res;
						mem_we_next    = 1'b1;
					end else begin
						acc_next = sub_res;
					end
					flags_next.carry_flag        = sub_full[DW];
					flags_next.aux_carry_flag    = sub_low[4];
					flags_next.overflow_flag     = sub_ovfl;
					flags_next.zero_flag         =
						(sub_res == rsa_pkg::BYTE_ZERO);
					flags_next.signed_carry_flag =
						sub_res[DW-1] ^ sub_ovfl;
					// Chained zero: borrow forms keep multi-byte history
					if ((cmd.op == rsa_pkg::RSA_PLAIN_SUBTRACT)
					    || (cmd.op == rsa_pkg::RSA_PLAIN_SUBTRACT_IMM)
					    || (cmd.op == rsa_pkg::RSA_PLAIN_SUBTRACT_TO_MEM)) begin
						flags_next.carry_zero_flag =
							(sub_res == rsa_pkg::BYTE_ZERO);
					end else begin
						flags_next.carry_zero_flag =
							(sub_res == rsa_pkg::BYTE_ZERO)
							&& flags_reg.carry_zero_flag;
					end
				end
				rsa_pkg::RSA_DECREMENT_SKIP_ZERO: begin
					mem_wdata_next = dec_res;
					mem_we_next    = 1'b1;
					skip_next_v    = (dec_res == rsa_pkg::BYTE_ZERO);
				end
				rsa_pkg::RSA_DECREMENT_SKIP_ZERO_TO_ACC: begin
					acc_next    = dec_res;
					skip_next_v = (dec_res == rsa_pkg::BYTE_ZERO);
				end
				rsa_pkg::RSA_INCREMENT_SKIP_ZERO: begin
					mem_wdata_next = inc_res;
					mem_we_next    = 1'b1;
					skip_next_v    = (inc_res == rsa_pkg::BYTE_ZERO);
				end
				rsa_pkg::RSA_INCREMENT_SKIP_ZERO_TO_ACC: begin
					acc_next    = inc_res;
					skip_next_v = (inc_res == rsa_pkg::BYTE_ZERO);
				end
				rsa_pkg::RSA_SKIP_IF_NONZERO: begin
					skip_next_v = (mem_val != rsa_pkg::BYTE_ZERO);
				end
				rsa_pkg::RSA_SKIP_IF_NONZERO_BIT: begin
					skip_next_v = |(mem_val & bit_mask(cmd.bit_sel));
				end
				rsa_pkg::RSA_SET_BYTE: begin
					mem_wdata_next = rsa_pkg::BYTE_ONES;
					mem_we_next    = 1'b1;
				end
				rsa_pkg::RSA_SET_BIT: begin
					mem_wdata_next = mem_val | bit_mask(cmd.bit_sel);
					mem_we_next    = 1'b1;
				end
				default: begin
					// No operation and unused codes leave all state alone
					mem_we_next = 1'b0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------

	// Synchronous reset; all state lands on constants
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_reg     <= rsa_pkg::RSA_ST_EXEC;
			flags_reg     <= rsa_pkg::FLAGS_RST;
			acc_reg       <= rsa_pkg::ACC_RST;
			mem_wdata_reg <= rsa_pkg::BYTE_ZERO;
			mem_we_reg    <= 1'b0;
			skip_reg      <= 1'b0;
		end else begin
			state_reg     <= state_next;
			flags_reg     <= flags_next;
			acc_reg       <= acc_next;
			mem_wdata_reg <= mem_wdata_next;
			mem_we_reg    <= mem_we_next;
			skip_reg      <= skip_next_v;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------

	// Ready drops for the dummy slot so no command lands on it
	assign cmd_ready   = (state_reg == rsa_pkg::RSA_ST_EXEC);
	assign dummy_cycle = (state_reg == rsa_pkg::RSA_ST_DUMMY);
	assign mem_we      = mem_we_reg;
	assign mem_wdata   = mem_wdata_reg;
	assign skip_next   = skip_reg;
	assign accumulator = acc_reg;
	assign flags       = flags_reg;

endmodule

// ==== hdl/rsa_pkg.sv ====
// Package for the rotate, subtract and skip datapath: types and constants
package rsa_pkg;

	// ------------------------------------------------------------
	// Widths and constants
	// ------------------------------------------------------------
	localparam int        DATA_W      = 8;
	localparam int        BIT_SEL_W   = 3;
	localparam int        MSB_POS     = 7;
	localparam int        LSB_POS     = 0;
	localparam int        NIB_W       = 4;
	localparam logic [7:0] ACC_RST    = 8'h00;
	localparam logic [7:0] BYTE_ONES  = 8'hFF;
	localparam logic [7:0] BYTE_ZERO  = 8'h00;
	localparam logic [7:0] STEP_ONE   = 8'h01;

	// ------------------------------------------------------------
	// Operation codes
	// ------------------------------------------------------------
	typedef enum logic [4:0] {
		RSA_NOP                           = 5'h00,
		RSA_ROTATE_LEFT_IN_PLACE          = 5'h01,
		RSA_ROTATE_LEFT_TO_ACC            = 5'h02,
		RSA_ROTATE_LEFT_THRU_CARRY        = 5'h03,
		RSA_ROTATE_LEFT_THRU_CARRY_TO_ACC = 5'h04,
		RSA_ROTATE_RIGHT_IN_PLACE         = 5'h05,
		RSA_ROTATE_RIGHT_TO_ACC           = 5'h06,
		RSA_ROTATE_RIGHT_THRU_CARRY       = 5'h07,
		RSA_ROTATE_RIGHT_THRU_CARRY_TO_ACC= 5'h08,
		RSA_SUBTRACT_WITH_BORROW          = 5'h09,
		RSA_SUBTRACT_WITH_BORROW_IMM      = 5'h0A,
		RSA_SUBTRACT_WITH_BORROW_TO_MEM   = 5'h0B,
		RSA_PLAIN_SUBTRACT                = 5'h0C,
		RSA_PLAIN_SUBTRACT_IMM            = 5'h0D,
		RSA_PLAIN_SUBTRACT_TO_MEM         = 5'h0E,
		RSA_DECREMENT_SKIP_ZERO           = 5'h0F,
		RSA_DECREMENT_SKIP_ZERO_TO_ACC    = 5'h10,
		RSA_INCREMENT_SKIP_ZERO           = 5'h11,
		RSA_INCREMENT_SKIP_ZERO_TO_ACC    = 5'h12,
		RSA_SKIP_IF_NONZERO               = 5'h13,
		RSA_SKIP_IF_NONZERO_BIT           = 5'h14,
		RSA_SET_BYTE                      = 5'h15,
		RSA_SET_BIT                       = 5'h16
	} rsa_op_t;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		rsa_op_t        op;
		logic [7:0]     mem_data;
		logic [7:0]     imm;
		logic [2:0]     bit_sel;
	} rsa_cmd_t;

	typedef struct packed {
		logic overflow_flag;
		logic zero_flag;
		logic aux_carry_flag;
		logic carry_flag;
		logic signed_carry_flag;
		logic carry_zero_flag;
	} rsa_flags_t;

	localparam rsa_flags_t FLAGS_RST = '0;

	// Sequencer states, Gray coded
	typedef enum logic [1:0] {
		RSA_ST_EXEC  = 2'b00,
		RSA_ST_DUMMY = 2'b01
	} rsa_state_t;

endpackage

// ==== verification/rsa_alu_props.sv ====
// Checker for the rotate, subtract and skip datapath
module rsa_alu_props #(
	parameter int DW = 8
) (
	// Clock and reset
	input wire logic                sys_clk,
	input wire logic                rst_n,
	// Command and preload
	input wire logic                cmd_valid,
	input wire rsa_pkg::rsa_cmd_t   cmd,
	input wire logic                cmd_ready,
	input wire logic                acc_load,
	input wire logic [DW-1:0]       acc_load_data,
	input wire logic                flags_load,
	input wire rsa_pkg::rsa_flags_t flags_load_data,
	// Results
	input wire logic                mem_we,
	input wire logic [DW-1:0]       mem_wdata,
	input wire logic                skip_next,
	input wire logic                dummy_cycle,
	input wire logic [DW-1:0]       accumulator,
	input wire rsa_pkg::rsa_flags_t flags
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	logic [7:0] m;
	logic       tk;
	// Operand as taken; results land one cycle after the taking edge
	assign m = cmd.mem_data;
	assign tk = cmd_valid && cmd_ready;

	AST_SKIP_TWO: assert property (tk && cmd.op inside {[5'h0F:5'h14]}
		|=> dummy_cycle && !cmd_ready ##1 !dummy_cycle)
		else $error("Skip op did not take two cycles");
	AST_SET_BYTE: assert property (tk && cmd.op == rsa_pkg::RSA_SET_BYTE
		|=> mem_we && mem_wdata == 8'hFF)
		else $error("Byte set did not write all ones");
	AST_ROT_LEFT_ACCUM: assert property (tk && cmd.op == 5'h02
		&& !flags_load
		|=> accumulator == {$past(m[6:0]), $past(m[7])} && !mem_we
		&& flags == $past(flags))
		else $error("Left rotate to accumulator wrong");
	AST_ROT_RIGHT_MEM: assert property (tk && cmd.op == 5'h05
		|=> mem_we && mem_wdata == {$past(m[0]), $past(m[7:1])})
		else $error("Right rotate in place wrong");
	AST_ROT_LEFT_CARRY: assert property (tk && cmd.op == 5'h03
		|=> mem_wdata == {$past(m[6:0]), $past(flags.carry_flag)}
		&& flags.carry_flag == $past(m[7]))
		else $error("Left rotate through carry wrong");
	AST_DEC_SKIP: assert property (tk && cmd.op == 5'h0F
		|=> mem_we && mem_wdata == $past(m) - 8'h01
		&& skip_next == ($past(m) == 8'h01))
		else $error("Decrement and skip wrong");
	AST_INC_ACCUM: assert property (tk && cmd.op == 5'h12
		|=> accumulator == $past(m) + 8'h01 && !mem_we
		&& skip_next == ($past(m) == 8'hFF))
		else $error("Increment to accumulator wrong");
	AST_SKIP_NONZERO: assert property (tk && cmd.op == 5'h13
		|=> skip_next == ($past(m) != 8'h00) && !mem_we)
		else $error("Skip on nonzero wrong");
	AST_SET_BIT: assert property (tk && cmd.op == 5'h16
		|=> mem_wdata == ($past(m) | (8'h01 << $past(cmd.bit_sel))))
		else $error("Bit set wrong");
	AST_SUB_C: assert property (tk && cmd.op == 5'h0C
		|=> flags.carry_flag == ($past(accumulator) >= $past(m)))
		else $error("Subtract carry wrong");
	// Main scenarios
	CV_SKIP: cover property (tk && cmd.op == 5'h0F ##1 skip_next);
	CV_SUB: cover property (tk && cmd.op == 5'h0B ##1 mem_we);
	CV_SET: cover property (tk && cmd.op == 5'h16 ##1 mem_we);
endmodule

bind rsa_alu rsa_alu_props #(.DW(DW)) i_props (.sys_clk(sys_clk),
	.rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd),
	.cmd_ready(cmd_ready), .acc_load(acc_load),
	.acc_load_data(acc_load_data), .flags_load(flags_load),
	.flags_load_data(flags_load_data), .mem_we(mem_we),
	.mem_wdata(mem_wdata), .skip_next(skip_next),
	.dummy_cycle(dummy_cycle), .accumulator(accumulator),
	.flags(flags));

// ==== verification/rsa_mem_model.sv ====
// Data memory byte at the far side of the datapath
module rsa_mem_model (
	input wire logic       sys_clk,
	input wire logic       load,
	input wire logic [7:0] load_data,
	input wire logic       mem_we,
	input wire logic [7:0] mem_wdata,
	output logic [7:0]     mem_byte
);
	timeunit 1ns;
	timeprecision 1ns;
	// Write-back wins; the sequencer never preloads in a write cycle
	always_ff @(posedge sys_clk) begin
		if (mem_we)
			mem_byte <= mem_wdata;
		else if (load)
			mem_byte <= load_data;
	end
endmodule

// ==== verification/tb_top.sv ====
// Self-checking bench of the rotate, subtract and skip datapath
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk, rst_n, cmd_valid, cmd_ready, acc_load, flags_load;
	logic mem_we, skip_next, dummy_cycle, ld;
	logic [7:0] acc_load_data, mem_wdata, accumulator, mem_byte, ld_data;
	logic [7:0] ea, em, ew;
	logic [31:0] seed, rv;
	logic [23:0] dir [11] = '{24'h0F0100, 24'h0F0000, 24'h11FF00,
		24'h12FF00, 24'h100100, 24'h130000, 24'h140000, 24'h0C807F,
		24'h0C5555, 24'h090100, 24'h0B7F80};
	rsa_pkg::rsa_cmd_t cmd;
	rsa_pkg::rsa_flags_t flags_load_data, flags, ef;
	int mismatches, comparisons;

	rsa_alu i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
		.cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
		.acc_load(acc_load), .acc_load_data(acc_load_data),
		.flags_load(flags_load), .flags_load_data(flags_load_data),
		.mem_we(mem_we), .mem_wdata(mem_wdata), .skip_next(skip_next),
		.dummy_cycle(dummy_cycle), .accumulator(accumulator),
		.flags(flags));
	rsa_mem_model i_mem (.sys_clk(sys_clk), .load(ld),
		.load_data(ld_data), .mem_we(mem_we), .mem_wdata(mem_wdata),
		.mem_byte(mem_byte));

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %0h seen %0h", n, exp, seen);
		end
	endtask
	task automatic close_out();
		if (mismatches == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Preload memory, accumulator and flags for one cycle
	task automatic preload(logic [7:0] mv, av, logic [5:0] fv);
		@(posedge sys_clk);
		{ld, acc_load, flags_load} <= 3'h7;
		{ld_data, acc_load_data, flags_load_data} <= {mv, av, fv};
		@(posedge sys_clk);
		{ld, acc_load, flags_load} <= 3'h0;
		{em, ea, ef} = {mv, av, fv};
		#1;
	endtask
	// One command against the reference; the operand comes from memory
	task automatic run_op(logic [4:0] op, logic [7:0] imm, logic [2:0] sl);
		logic [7:0] m, r, b;
		logic [8:0] s;
		logic we, sk, ci;
		we = 1'b0;
		sk = 1'b0;
		// The last write-back lands one edge after its pulse: wait it out
		@(posedge sys_clk);
		#1;
		m = mem_byte;
		chk("memory", mem_byte, em);
		@(posedge sys_clk);
		cmd_valid <= 1'b1;
		cmd <= '{rsa_pkg::rsa_op_t'(op), m, imm, sl};
		#1;
		chk("cmd_ready", cmd_ready, 1'b1);
		@(posedge sys_clk);
		cmd_valid <= 1'b0;
		case (op)
			5'h01: {we, r} = {1'b1, m[6:0], m[7]};
			5'h02: ea = {m[6:0], m[7]};
			5'h03: {we, r, ef.carry_flag} = {1'b1, m[6:0], ef.carry_flag, m[7]};
			5'h04: {ea, ef.carry_flag} = {m[6:0], ef.carry_flag, m[7]};
			5'h05: {we, r} = {1'b1, m[0], m[7:1]};
			5'h06: ea = {m[0], m[7:1]};
			5'h07: {we, ef.carry_flag, r} = {1'b1, m[0], ef.carry_flag, m[7:1]};
			5'h08: {ef.carry_flag, ea} = {m[0], ef.carry_flag, m[7:1]};
			5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E: begin
				b = (op == 5'h0A || op == 5'h0D) ? imm : m;
				ci = (op < 5'h0C) ? ef.carry_flag : 1'b1;
				s = {1'b0, ea} + {1'b0, ~b} + ci;
				r = s[7:0];
				ef.aux_carry_flag = ({1'b0, ea[3:0]} + {1'b0, ~b[3:0]} + ci) > 5'h0F;
				ef.carry_flag = s[8];
				ef.overflow_flag = (ea[7] != b[7]) && (r[7] != ea[7]);
				ef.signed_carry_flag = r[7] ^ ef.overflow_flag;
				ef.carry_zero_flag = (r == 0) && (op >= 5'h0C || ef.carry_zero_flag);
				ef.zero_flag = r == 8'h00;
				if (op == 5'h0B || op == 5'h0E)
					we = 1'b1;
				else
					ea = r;
			end
			5'h0F: {we, r, sk} = {1'b1, m - 8'h01, m == 8'h01};
			5'h10: {ea, sk} = {m - 8'h01, m == 8'h01};
			5'h11: {we, r, sk} = {1'b1, m + 8'h01, m == 8'hFF};
			5'h12: {ea, sk} = {m + 8'h01, m == 8'hFF};
			5'h13: sk = m != 8'h00;
			5'h14: sk = m[sl];
			5'h15: {we, r} = {1'b1, 8'hFF};
			5'h16: {we, r} = {1'b1, m | (8'h01 << sl)};
			default: ;
		endcase
		if (we)
			{em, ew} = {r, r};
		#1;
		chk("accumulator", accumulator, ea);
		chk("flags", flags, ef);
		chk("mem_we", mem_we, we);
		chk("mem_wdata", mem_wdata, ew);
		chk("skip_next", skip_next, sk);
		chk("dummy_cycle", dummy_cycle, op inside {[5'h0F:5'h14]});
	endtask

	// Free-running system clock
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	// Watchdog: a few thousand cycles are expected, ten thousand allowed
	initial begin
		#400000;
		mismatches++;
		close_out();
	end
	// Main sequence: reset, boundary table, then random traffic
	initial begin
		{rst_n, cmd_valid, acc_load, flags_load, ld} = 5'h0;
		{cmd, acc_load_data, flags_load_data, ld_data} = '0;
		{mismatches, comparisons, ew} = '0;
		seed = 32'hAED13B20;
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		#1;
		chk("reset accumulator", accumulator, 8'h00);
		chk("reset flags", flags, 6'h00);
		foreach (dir[i]) begin
			rv = xs();
			preload(dir[i][15:8], dir[i][7:0], rv[5:0]);
			run_op(dir[i][20:16], rv[15:8], rv[18:16]);
		end
		repeat (600) begin
			rv = xs();
			if (rv[1:0] == 2'h0)
				preload(rv[15:8], rv[23:16], rv[29:24]);
			rv = xs();
			run_op(rv[4:0], rv[12:5], rv[15:13]);
		end
		close_out();
	end
endmodule
